/* verilog/eprom_pkg.sv */
`default_nettype none
package eprom_pkg;
	// command codes carried in the first byte after a bus reset
	localparam logic [7:0] CMD_READ_PAGE = 8'hC3;
	localparam logic [7:0] CMD_PROG_MAIN = 8'h0F;
	localparam logic [7:0] CMD_PROG_STAT = 8'h55;
	// field sizes in bytes
	localparam int MAIN_BYTES = 128;
	localparam int STAT_BYTES = 8;
	localparam int PAGE_BYTES = 32;
	localparam logic [4:0] PAGE_LAST = 5'h1F;
	localparam logic [7:0] BLANK_BYTE = 8'hFF;
	localparam logic [7:0] FACTORY_STAT = 8'h00;
	localparam logic [7:0] CRC_ZERO = 8'h00;
	// x^8+x^5+x^4+1 in reflected form, lsb first
	localparam logic [7:0] CRC_POLY_REFL = 8'h8C;
	// program pulse length
	localparam int CLK_HZ = 25_000_000;
	localparam int PROG_TIME_US = 480;
	localparam int PROG_CYC = PROG_TIME_US * (CLK_HZ / 1_000_000);
	localparam int FIFO_DEPTH = 32;
	localparam int RETRY_LIMIT = 3;

	typedef enum logic [8:0] {
		S_CMD = 9'h001, S_ALO = 9'h002, S_AHI = 9'h004, S_DAT = 9'h008, S_HCRC = 9'h010,
		S_RDAT = 9'h020, S_PCRC = 9'h040, S_VER = 9'h080, S_ONES = 9'h100
	} dev_state_type;

	typedef enum logic [5:0] {
		M_IDLE = 6'h01, M_RST = 6'h02, M_TX = 6'h04, M_RX = 6'h08, M_SEQ = 6'h10, M_PROG = 6'h20
	} mst_state_type;

	typedef enum logic [8:0] {
		P_CMD = 9'h001, P_ALO = 9'h002, P_AHI = 9'h004, P_DAT = 9'h008, P_HCRC = 9'h010,
		P_RDAT = 9'h020, P_PCRC = 9'h040, P_PROG = 9'h080, P_VER = 9'h100
	} phase_type;

	// one bit into the crc generator, lsb first
	function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic b);
		crc8_step = {1'b0, c[7:1]} ^ ((c[0] ^ b) ? CRC_POLY_REFL : CRC_ZERO);
	endfunction
endpackage
`default_nettype wire

/* verilog/eprom_link_if.sv */
`timescale 1ns/1ns
`default_nettype none
// slot-level view of the single-wire link; one slot per req/ack pair
interface eprom_link_if;
	logic bus_rst;
	logic slot_req;
	logic slot_wr;
	logic slot_bit;
	logic prog;
	logic slot_ack;
	logic rd_bit;
	modport master (output bus_rst, output slot_req, output slot_wr, output slot_bit, output prog,
		input slot_ack, input rd_bit);
	modport device (input bus_rst, input slot_req, input slot_wr, input slot_bit, input prog,
		output slot_ack, output rd_bit);
endinterface
`default_nettype wire

/* verilog/sync_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module sync_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r, rp_r;
	logic [AW:0] cnt_r;
	logic push, pop;

	// full and empty straight from the occupancy count
	assign in_ready = cnt_r != (AW+1)'(DEPTH);
	assign out_valid = cnt_r != '0;
	assign out_data = mem[rp_r];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wp_r] <= in_data;
		end
	end

	// depth is a power of two, so pointers wrap by themselves
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) wp_r <= wp_r + 1'b1;
			if (pop) rp_r <= rp_r + 1'b1;
			if (push && !pop) cnt_r <= cnt_r + 1'b1;
			else if (pop && !push) cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule
`default_nettype wire

/* verilog/eprom_device.sv */
// Notes on behaviour
// (RULE_01) paged read: command, address low, address high
// (RULE_02) read header crc covers command and address
// (RULE_03) master resets and retries on header mismatch
// (RULE_04) data to page end, then page crc
// (RULE_05) next page follows, 32 data plus crc
// (RULE_06) after last page crc, ones until reset
// (RULE_07) bus reset aborts any command to idle
// (RULE_08) program: command, address, data, then crc
// (RULE_09) blank reads ones; programming only clears bits
// (RULE_10) master pulses only after matching crc
// (RULE_11) verify returns addressed byte, lsb first
// (RULE_12) master reprograms when verify shows stray ones
// (RULE_13) address increments after verify, always
// (RULE_14) next pass: load address low, shift data
// (RULE_15) master sends next data, reads crc, continues; this master resets the bus after each verify instead
// (RULE_16) first pass crc: command, address, data shifted
// (RULE_17) every program pulse programs the scratchpad
// (RULE_18) status program mirrors main program sequence
// (RULE_19) status bytes 0-6 blank ones, byte 7 zero
// (RULE_20) every byte moves least significant bit first
// (RULE_21) protected page refuses programming, still reads
// (RULE_22) crc poly x8+x5+x4+1, lsb first, cleared
`timescale 1ns/1ns
`default_nettype none
module eprom_device
	import eprom_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	eprom_link_if.device link,
	output logic active,
	output logic prog_done
);
	dev_state_type st_r;
	logic [2:0] cnt_r;
	logic [7:0] sh_r, crc_r, cmd_r, scratch_r, cur_byte, in_byte;
	logic [15:0] addr_r, addr_inc;
	logic ack_r, rbit_r, prog_d_r, active_r, prog_done_r;
	logic tx_bit, wslot, rslot, byte_end, stat_sel, prog_fall, prot_ok;
	logic [7:0] main_mem [MAIN_BYTES];
	logic [7:0] stat_mem [STAT_BYTES-1];

	assign link.slot_ack = ack_r;
	assign link.rd_bit = rbit_r;
	assign active = active_r;
	assign prog_done = prog_done_r;

	assign wslot = link.slot_req & link.slot_wr;
	assign rslot = link.slot_req & ~link.slot_wr;
	assign byte_end = cnt_r == 3'h7;
	assign in_byte = {link.slot_bit, sh_r[7:1]}; // RULE_20
	assign addr_inc = addr_r + 16'h0001;
	assign stat_sel = cmd_r == CMD_PROG_STAT; // RULE_18
	assign prog_fall = prog_d_r & ~link.prog;
	// protect bit of the page still reads one while unprogrammed
	assign prot_ok = stat_mem[0][addr_r[6:5]]; // RULE_21

	// byte at the current address; beyond a field reads blank
	always_comb begin
		cur_byte = BLANK_BYTE;
		if (stat_sel) begin
			if (addr_r < 16'(STAT_BYTES - 1)) cur_byte = stat_mem[addr_r[2:0]];
			else if (addr_r == 16'(STAT_BYTES - 1)) cur_byte = FACTORY_STAT; // RULE_19
		end else if (addr_r < 16'(MAIN_BYTES)) begin
			cur_byte = main_mem[addr_r[6:0]];
		end
	end

	// bit the device puts into the next read slot
	always_comb begin
		case (st_r)
			S_HCRC, S_PCRC: tx_bit = crc_r[cnt_r]; // RULE_20
			S_RDAT, S_VER: tx_bit = cur_byte[cnt_r]; // RULE_11
			default: tx_bit = 1'b1; // RULE_06
		endcase
	end

	// command sequencer; slots of the wrong direction are answered and ignored
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_r <= S_CMD;
			cnt_r <= 3'h0;
			sh_r <= 8'h00;
			crc_r <= CRC_ZERO;
			cmd_r <= 8'h00;
			addr_r <= 16'h0000;
			scratch_r <= BLANK_BYTE;
		end else if (link.bus_rst) begin
			st_r <= S_CMD; // RULE_07
			cnt_r <= 3'h0;
			crc_r <= CRC_ZERO; // RULE_22
		end else begin
			case (st_r)
				S_CMD, S_ALO, S_AHI, S_DAT: begin
					if (wslot) begin
						sh_r <= in_byte;
						crc_r <= crc8_step(crc_r, link.slot_bit); // RULE_16
						cnt_r <= cnt_r + 3'h1;
						if (byte_end) begin
							case (st_r)
								S_CMD: begin
									cmd_r <= in_byte;
									if (in_byte == CMD_READ_PAGE || in_byte == CMD_PROG_MAIN ||
										in_byte == CMD_PROG_STAT) st_r <= S_ALO;
									else st_r <= S_ONES;
								end
								S_ALO: begin
									addr_r[7:0] <= in_byte; // RULE_01
									st_r <= S_AHI;
								end
								S_AHI: begin
									addr_r[15:8] <= in_byte; // RULE_01
									st_r <= (cmd_r == CMD_READ_PAGE) ? S_HCRC : S_DAT; // RULE_02
								end
								default: begin
									scratch_r <= in_byte; // RULE_08
									st_r <= S_HCRC;
								end
							endcase
						end
					end
				end
				S_HCRC: begin
					if (rslot) begin
						cnt_r <= cnt_r + 3'h1;
						if (byte_end) begin
							if (cmd_r == CMD_READ_PAGE) begin
								crc_r <= CRC_ZERO; // RULE_04
								st_r <= (addr_r >= 16'(MAIN_BYTES)) ? S_ONES : S_RDAT;
							end else begin
								st_r <= S_VER;
							end
						end
					end
				end
				S_RDAT: begin
					if (rslot) begin
						crc_r <= crc8_step(crc_r, tx_bit); // RULE_04
						cnt_r <= cnt_r + 3'h1;
						if (byte_end) begin
							addr_r <= addr_inc;
							if (addr_r[4:0] == PAGE_LAST) st_r <= S_PCRC; // RULE_04
						end
					end
				end
				S_PCRC: begin
					if (rslot) begin
						cnt_r <= cnt_r + 3'h1;
						if (byte_end) begin
							crc_r <= CRC_ZERO; // RULE_05
							st_r <= (addr_r >= 16'(MAIN_BYTES)) ? S_ONES : S_RDAT; // RULE_06
						end
					end
				end
				S_VER: begin
					if (rslot) begin
						cnt_r <= cnt_r + 3'h1;
						if (byte_end) begin
							addr_r <= addr_inc; // RULE_13
							crc_r <= addr_inc[7:0]; // RULE_14
							st_r <= S_DAT;
						end
					end
				end
				default: st_r <= S_ONES;
			endcase
		end
	end

	// slot answer one cycle after each request; a bus reset cancels it
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ack_r <= 1'b0;
			rbit_r <= 1'b1;
		end else begin
			ack_r <= link.slot_req & ~link.bus_rst;
			rbit_r <= rslot ? tx_bit : 1'b1;
		end
	end

	// array cells; the pulse programs at its trailing edge whatever the crc said
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			prog_d_r <= 1'b0;
			for (int i = 0; i < MAIN_BYTES; i++) main_mem[i] <= BLANK_BYTE; // RULE_09
			for (int i = 0; i < STAT_BYTES - 1; i++) stat_mem[i] <= BLANK_BYTE; // RULE_19
		end else begin
			prog_d_r <= link.prog;
			if (prog_fall && st_r == S_VER) begin // RULE_17
				if (stat_sel) begin
					if (addr_r < 16'(STAT_BYTES - 1))
						stat_mem[addr_r[2:0]] <= stat_mem[addr_r[2:0]] & scratch_r; // RULE_18
				end else if (addr_r < 16'(MAIN_BYTES) && prot_ok) begin // RULE_21
					main_mem[addr_r[6:0]] <= main_mem[addr_r[6:0]] & scratch_r; // RULE_09
				end
			end
		end
	end

	// user-side status flags
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			active_r <= 1'b0;
			prog_done_r <= 1'b0;
		end else begin
			active_r <= st_r != S_CMD;
			prog_done_r <= prog_fall && st_r == S_VER;
		end
	end
endmodule
`default_nettype wire

/* verilog/eprom_master.sv */
`timescale 1ns/1ns
`default_nettype none
module eprom_master
	import eprom_pkg::*;
#(
	parameter int PROG_CYCLES = PROG_CYC,
	parameter int RETRIES = RETRY_LIMIT
) (
	input wire logic clk_sys,
	input wire logic rst,
	eprom_link_if.master link,
	input wire logic start,
	input wire logic [7:0] cmd,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] len,
	output logic busy,
	output logic done,
	output logic err,
	output logic rd_valid,
	output logic [7:0] rd_data,
	input wire logic rd_ready
);
	localparam int PCW = $clog2(PROG_CYCLES + 1);
	mst_state_type ms_r;
	phase_type ph_r;
	logic [2:0] cnt_r;
	logic [7:0] sh_r, crc_r, cmd_l, wd_l, left_r, push_data_r, rx_byte;
	logic [15:0] addr_l, a_r;
	logic [PCW-1:0] pc_r;
	logic [3:0] tries_r;
	logic pend_r, req_r, wr_r, bit_r, rst_r, prog_r, busy_r, done_r, err_r, push_r, f_ready;

	assign link.slot_req = req_r;
	assign link.slot_wr = wr_r;
	assign link.slot_bit = bit_r;
	assign link.bus_rst = rst_r;
	assign link.prog = prog_r;
	assign busy = busy_r;
	assign done = done_r;
	assign err = err_r;
	assign rx_byte = {link.rd_bit, sh_r[7:1]};

	// read data waits here; a full fifo holds off the next data read slot
	sync_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rd_fifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.in_valid(push_r),
		.in_ready(f_ready),
		.in_data(push_data_r),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_data)
	);

	// slot engine and command sequencer
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ms_r <= M_IDLE;
			ph_r <= P_CMD;
			cnt_r <= 3'h0;
			sh_r <= 8'h00;
			crc_r <= CRC_ZERO;
			cmd_l <= 8'h00;
			wd_l <= 8'h00;
			left_r <= 8'h00;
			addr_l <= 16'h0000;
			a_r <= 16'h0000;
			pc_r <= '0;
			tries_r <= 4'h0;
			pend_r <= 1'b0;
			req_r <= 1'b0;
			wr_r <= 1'b0;
			bit_r <= 1'b1;
			rst_r <= 1'b0;
			prog_r <= 1'b0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
			err_r <= 1'b0;
			push_r <= 1'b0;
			push_data_r <= 8'h00;
		end else begin
			req_r <= 1'b0;
			rst_r <= 1'b0;
			done_r <= 1'b0;
			push_r <= 1'b0;
			case (ms_r)
				M_IDLE: begin
					if (start) begin
						cmd_l <= cmd;
						wd_l <= wdata;
						addr_l <= addr;
						left_r <= len;
						tries_r <= 4'h0;
						busy_r <= 1'b1;
						err_r <= 1'b0;
						rst_r <= 1'b1;
						ms_r <= M_RST;
					end
				end
				M_RST: begin
					// header restarts from scratch after every bus reset
					crc_r <= CRC_ZERO;
					sh_r <= cmd_l;
					a_r <= addr_l;
					cnt_r <= 3'h0;
					pend_r <= 1'b0;
					ph_r <= P_CMD;
					ms_r <= M_TX;
				end
				M_TX: begin
					if (!pend_r) begin
						req_r <= 1'b1;
						wr_r <= 1'b1;
						bit_r <= sh_r[0]; // RULE_20
						crc_r <= crc8_step(crc_r, sh_r[0]);
						pend_r <= 1'b1;
					end else if (link.slot_ack) begin
						pend_r <= 1'b0;
						sh_r <= {1'b0, sh_r[7:1]};
						cnt_r <= cnt_r + 3'h1;
						if (cnt_r == 3'h7) ms_r <= M_SEQ;
					end
				end
				M_RX: begin
					if (!pend_r) begin
						// a push still in flight is not yet counted in the buffer's ready; wait for it
						if (ph_r != P_RDAT || (f_ready && !push_r)) begin
							req_r <= 1'b1;
							wr_r <= 1'b0;
							bit_r <= 1'b1;
							pend_r <= 1'b1;
						end
					end else if (link.slot_ack) begin
						pend_r <= 1'b0;
						sh_r <= rx_byte;
						if (ph_r == P_RDAT) crc_r <= crc8_step(crc_r, link.rd_bit);
						cnt_r <= cnt_r + 3'h1;
						if (cnt_r == 3'h7) ms_r <= M_SEQ;
					end
				end
				M_PROG: begin
					pc_r <= pc_r + 1'b1;
					if (pc_r == PCW'(PROG_CYCLES - 1)) begin
						prog_r <= 1'b0;
						ph_r <= P_VER;
						ms_r <= M_RX;
					end
				end
				M_SEQ: begin
					ms_r <= M_TX;
					case (ph_r)
						P_CMD: begin
							sh_r <= a_r[7:0]; // RULE_01
							ph_r <= P_ALO;
						end
						P_ALO: begin
							sh_r <= a_r[15:8];
							ph_r <= P_AHI;
						end
						P_AHI: begin
							if (cmd_l == CMD_READ_PAGE) begin
								ph_r <= P_HCRC;
								ms_r <= M_RX;
							end else begin
								sh_r <= wd_l; // RULE_08
								ph_r <= P_DAT;
							end
						end
						P_DAT: begin
							ph_r <= P_HCRC;
							ms_r <= M_RX;
						end
						P_HCRC: begin
							if (sh_r != crc_r) begin
								// mismatch: reset the bus and try again, bounded
								if (tries_r == 4'(RETRIES)) begin // RULE_03
									err_r <= 1'b1;
									busy_r <= 1'b0;
									done_r <= 1'b1;
									ms_r <= M_IDLE;
								end else begin
									tries_r <= tries_r + 4'h1;
									ms_r <= M_RST;
								end
								rst_r <= 1'b1;
							end else if (cmd_l == CMD_READ_PAGE) begin
								crc_r <= CRC_ZERO;
								if (left_r == 8'h00) begin
									rst_r <= 1'b1;
									busy_r <= 1'b0;
									done_r <= 1'b1;
									ms_r <= M_IDLE;
								end else begin
									ph_r <= P_RDAT;
									ms_r <= M_RX;
								end
							end else begin
								prog_r <= 1'b1; // RULE_10
								pc_r <= '0;
								ph_r <= P_PROG;
								ms_r <= M_PROG;
							end
						end
						P_RDAT: begin
							push_r <= 1'b1;
							push_data_r <= sh_r;
							left_r <= left_r - 8'h01;
							a_r <= a_r + 16'h0001;
							ms_r <= M_RX;
							if (a_r[4:0] == PAGE_LAST) begin
								ph_r <= P_PCRC;
							end else if (left_r == 8'h01) begin
								rst_r <= 1'b1;
								busy_r <= 1'b0;
								done_r <= 1'b1;
								ms_r <= M_IDLE;
							end
						end
						P_PCRC: begin
							if (sh_r != crc_r) err_r <= 1'b1;
							crc_r <= CRC_ZERO;
							ph_r <= P_RDAT;
							ms_r <= M_RX;
							if (left_r == 8'h00 || a_r >= 16'(MAIN_BYTES)) begin
								rst_r <= 1'b1;
								busy_r <= 1'b0;
								done_r <= 1'b1;
								ms_r <= M_IDLE;
							end
						end
						default: begin
							// verify: any one left where a zero was asked means reprogram, or err once the retries are used up
							if ((sh_r & ~wd_l) != 8'h00 && tries_r != 4'(RETRIES)) begin // RULE_12
								tries_r <= tries_r + 4'h1;
								ms_r <= M_RST;
							end else begin
								err_r <= (sh_r & ~wd_l) != 8'h00;
								busy_r <= 1'b0;
								done_r <= 1'b1;
								ms_r <= M_IDLE;
							end
							rst_r <= 1'b1;
						end
					endcase
				end
				default: ms_r <= M_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

/* verif/eprom_link_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module eprom_link_checker #(
	parameter int PROG_CYCLES = 4
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic bus_rst,
	input wire logic slot_req,
	input wire logic slot_wr,
	input wire logic slot_bit,
	input wire logic prog,
	input wire logic slot_ack,
	input wire logic rd_bit
);
	int prog_cnt_r;
	// length of the running program pulse, compared when it falls
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			prog_cnt_r <= 0;
		end else if (prog) begin
			prog_cnt_r <= prog_cnt_r + 1;
		end else begin
			prog_cnt_r <= 0;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	slot_answer_a: assert property (slot_req && !bus_rst |=> slot_ack)
		else $error("slot not answered");
	ack_cause_a: assert property (slot_ack |-> $past(slot_req) && !$past(bus_rst))
		else $error("answer without a slot");
	ack_pulse_a: assert property (slot_ack |=> !slot_ack)
		else $error("answer longer than one cycle");
	write_ones_a: assert property (slot_ack && $past(slot_wr) |-> rd_bit)
		else $error("device pulled a write slot low");
	abort_quiet_a: assert property (bus_rst |=> !slot_ack)
		else $error("answer after bus reset");
	prog_quiet_a: assert property (prog |-> !slot_req && !slot_ack)
		else $error("slot during program pulse");
	prog_len_a: assert property ($fell(prog) |-> prog_cnt_r == PROG_CYCLES)
		else $error("program pulse length wrong");
	req_gap_a: assert property (slot_req |=> !slot_req)
		else $error("slots too close");
	rst_pulse_a: assert property (bus_rst |=> !bus_rst)
		else $error("bus reset longer than one cycle");
endmodule
`default_nettype wire

/* verif/tb_eprom_memory_function_commands.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_eprom_memory_function_commands;
	import eprom_pkg::*;
	localparam int PC = 4;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	logic [7:0] cmd = 8'h00;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00;
	logic [7:0] len = 8'h00;
	logic rd_ready = 1'b0;
	logic busy, done, err, rd_valid, active, prog_done, active2, prog_done2;
	logic [7:0] rd_data;
	logic hold_rd = 1'b0;
	int pulses = 0;
	int bad_count = 0;
	int checked = 0;
	int seed = 32'h5825;
	logic [7:0] mem [0:127];
	logic [7:0] q [$];
	eprom_link_if link();
	eprom_link_if link2();
	eprom_master #(.PROG_CYCLES(PC), .RETRIES(RETRY_LIMIT)) eprom_master_inst (.clk_sys(clk_sys), .rst(rst),
		.link(link), .start(start), .cmd(cmd), .addr(addr), .wdata(wdata), .len(len), .busy(busy), .done(done),
		.err(err), .rd_valid(rd_valid), .rd_data(rd_data), .rd_ready(rd_ready));
	eprom_device eprom_device_inst (.clk_sys(clk_sys), .rst(rst), .link(link), .active(active),
		.prog_done(prog_done));
	// second device driven slot by slot from the bench, for wire-level checks
	eprom_device eprom_device_inst2 (.clk_sys(clk_sys), .rst(rst), .link(link2), .active(active2),
		.prog_done(prog_done2));
	eprom_link_checker #(.PROG_CYCLES(PC)) eprom_link_checker_inst (.clk_sys(clk_sys), .rst(rst),
		.bus_rst(link.bus_rst), .slot_req(link.slot_req), .slot_wr(link.slot_wr), .slot_bit(link.slot_bit),
		.prog(link.prog), .slot_ack(link.slot_ack), .rd_bit(link.rd_bit));
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	// random consumer stalls on the read stream
	initial begin
		forever begin
			@(posedge clk_sys);
			#2;
			rd_ready = !hold_rd && (($random(seed) & 3) != 0);
		end
	end
	// every byte leaving the master's buffer, and every pulse the main device took in verify, protected page or not
	always @(posedge clk_sys) begin
		if (rd_valid === 1'b1 && rd_ready === 1'b1) q.push_back(rd_data);
		if (prog_done === 1'b1) pulses++;
	end
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// reference crc, lsb first, reflected polynomial
	function automatic logic [7:0] crc_add(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] r;
		r = c;
		for (int i = 0; i < 8; i++) r = (r[0] ^ b[i]) ? ((r >> 1) ^ 8'h8C) : (r >> 1);
		return r;
	endfunction
	// one slot: request for one cycle, answer looked at in the next
	task automatic slot(input logic wr, input logic b, output logic rb);
		@(posedge clk_sys);
		#2;
		link2.slot_req = 1'b1;
		link2.slot_wr = wr;
		link2.slot_bit = b;
		@(posedge clk_sys);
		#2;
		link2.slot_req = 1'b0;
		link2.slot_bit = 1'b1;
		check8("slot_ack", 8'h01, {7'h00, link2.slot_ack});
		rb = link2.rd_bit;
	endtask
	task automatic put_byte(input logic [7:0] b);
		logic rb;
		for (int i = 0; i < 8; i++) slot(1'b1, b[i], rb);
	endtask
	task automatic get_byte(output logic [7:0] b);
		logic rb;
		for (int i = 0; i < 8; i++) begin
			slot(1'b0, 1'b1, rb);
			b[i] = rb;
		end
	endtask
	task automatic raw_reset;
		@(posedge clk_sys);
		#2;
		link2.bus_rst = 1'b1;
		@(posedge clk_sys);
		#2;
		link2.bus_rst = 1'b0;
	endtask
	task automatic raw_pass(input logic [7:0] crc0, input logic [7:0] d);
		logic [7:0] g;
		put_byte(d);
		get_byte(g);
		check8("pass crc", crc_add(crc0, d), g);
		@(posedge clk_sys);
		#2;
		link2.prog = 1'b1;
		repeat (PC) @(posedge clk_sys);
		#2;
		link2.prog = 1'b0;
		@(posedge clk_sys);
		#2;
		check8("prog done", 8'h01, {7'h00, prog_done2});
		get_byte(g);
		check8("verify byte", d, g);
	endtask
	// one master command, waiting for done under a bound
	task automatic run(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d, input logic [7:0] n,
		input logic exp_err);
		int w;
		@(posedge clk_sys);
		#2;
		start = 1'b1;
		cmd = c;
		addr = {8'h00, a};
		wdata = d;
		len = n;
		@(posedge clk_sys);
		#2;
		start = 1'b0;
		w = 0;
		while (done !== 1'b1 && w < 20000) begin
			@(posedge clk_sys);
			#2;
			w++;
		end
		check8("done", 8'h01, {7'h00, done});
		check8("err", {7'h00, exp_err}, {7'h00, err});
	endtask
	task automatic rd_check(input logic [7:0] a, input logic [7:0] n);
		q.delete();
		run(CMD_READ_PAGE, a, 8'h00, n, 1'b0);
		repeat (300) @(posedge clk_sys);
		check8("active", 8'h00, {7'h00, active});
		check8("read count", n, 8'(q.size()));
		for (int i = 0; i < n && i < q.size(); i++) check8("read data", mem[a + i], q[i]);
	endtask
	initial begin
		repeat (60000) @(posedge clk_sys);
		bad_count++;
		report_and_stop;
	end
	initial begin
		logic [7:0] a, d, n, g, c, d1, d2, e;
		link2.bus_rst = 1'b0;
		link2.slot_req = 1'b0;
		link2.slot_wr = 1'b0;
		link2.slot_bit = 1'b1;
		link2.prog = 1'b0;
		for (int i = 0; i < 128; i++) mem[i] = BLANK_BYTE;
		repeat (3) @(posedge clk_sys);
		#2;
		rst = 1'b0;
		// two passes of main programming on the raw link
		d1 = $random(seed);
		d2 = $random(seed);
		raw_reset;
		put_byte(CMD_PROG_MAIN);
		put_byte(8'h5F);
		put_byte(8'h00);
		raw_pass(crc_add(crc_add(crc_add(8'h00, CMD_PROG_MAIN), 8'h5F), 8'h00), d1);
		raw_pass(8'h60, d2);
		// header cut short, then a full paged read across a page end
		raw_reset;
		put_byte(CMD_READ_PAGE);
		put_byte(8'h11);
		raw_reset;
		put_byte(CMD_READ_PAGE);
		put_byte(8'h5E);
		put_byte(8'h00);
		get_byte(g);
		check8("header crc", crc_add(crc_add(crc_add(8'h00, CMD_READ_PAGE), 8'h5E), 8'h00), g);
		c = CRC_ZERO;
		for (int i = 8'h5E; i < 128; i++) begin
			get_byte(g);
			e = (i == 8'h5F) ? d1 : (i == 8'h60) ? d2 : BLANK_BYTE;
			check8("page data", e, g);
			c = crc_add(c, e);
			if (i[4:0] == PAGE_LAST) begin
				get_byte(g);
				check8("page crc", c, g);
				c = CRC_ZERO;
			end
		end
		for (int i = 0; i < 3; i++) begin
			get_byte(g);
			check8("after last page", BLANK_BYTE, g);
		end
		raw_reset;
		// unknown command: ones until a bus reset, then back to command wait
		put_byte(8'hA5);
		get_byte(g);
		check8("unknown cmd", BLANK_BYTE, g);
		check8("active", 8'h01, {7'h00, active2});
		raw_reset;
		@(posedge clk_sys);
		#2;
		check8("idle after reset", 8'h00, {7'h00, active2});
		// random writes through the master, read back at the boundary too
		for (int k = 0; k < 5; k++) begin
			a = (k == 0) ? 8'h7F : ($random(seed) & 8'h7F);
			d = $random(seed);
			run(CMD_PROG_MAIN, a, d, 8'h00, 1'b0);
			mem[a] = mem[a] & d;
			n = 8'h01 + ($random(seed) & 7);
			if (a + n > 128) n = 8'(128 - a);
			rd_check(a, n);
		end
		// protect page 1 through the status field; its bytes then refuse change
		run(CMD_PROG_STAT, 8'h00, 8'hFD, 8'h00, 1'b0);
		run(CMD_PROG_MAIN, 8'h25, 8'h00, 8'h00, 1'b1);
		rd_check(8'h24, 8'h03);
		check8("prog pulses", 8'h0A, 8'(pulses));
		// reader held off across a page end: the master must wait at a full buffer and lose nothing
		hold_rd = 1'b1;
		q.delete();
		@(posedge clk_sys);
		#2;
		start = 1'b1;
		cmd = CMD_READ_PAGE;
		addr = 16'h0010;
		len = 8'h28;
		@(posedge clk_sys);
		#2;
		start = 1'b0;
		repeat (3000) @(posedge clk_sys);
		check8("stalled busy", 8'h01, {7'h00, busy});
		check8("stalled valid", 8'h01, {7'h00, rd_valid});
		hold_rd = 1'b0;
		repeat (800) @(posedge clk_sys);
		check8("drain count", 8'h28, 8'(q.size()));
		for (int i = 0; i < 40 && i < q.size(); i++) check8("drain data", mem[16 + i], q[i]);
		check8("drain idle", 8'h00, {6'h00, busy, rd_valid});
		check8("drain err", 8'h00, {7'h00, err});
		report_and_stop;
	end
endmodule
`default_nettype wire
